// [include/xcbt_defines.svh]
// Constants for the XNOR chain board test block.
`ifndef XCBT_DEFINES_SVH
`define XCBT_DEFINES_SVH

`define XCBT_CHAIN_WIDTH 108
`define XCBT_OTHER_WIDTH 106
`define XCBT_FRAME_BIT 107
`define XCBT_AD0_BIT 106
`define XCBT_PIN_RESET 1'b1
`define XCBT_DISABLE_RESET 1'b0

`endif

// [include/xcbt_pkg.sv]
// Types for the XNOR chain board test block.
package xcbt_pkg;

    typedef enum logic [1:0] {
        XCBT_NORMAL = 2'b01,
        XCBT_TEST = 2'b10
    } xcbt_mode_t;

endpackage

// [logic/xcbt_board_test.sv]
// XNOR chain board test mode: entry, exit and the chain output pin.
`timescale 1ns/1ps
`default_nettype none
`include "xcbt_defines.svh"

// Contract
// R1 - The mode is entered when frame and address/data bit 0 are both low at host reset release.
// R2 - The mode is left when frame or address/data bit 0 is high at a host reset release.
// R3 - A core power-on reset always leaves the device out of the test mode.
// R4 - In test mode all normal pin drivers are released except the chain output pin.
// R5 - In test mode a change on any one chain input toggles the chain output.
// R6 - Every pin except supplies, grounds, the chain output, host reset and oscillator feeds the chain.
// R7 - Once in the mode, frame and address/data bit 0 are ordinary chain inputs.
// R8 - With all chain inputs low the chain output is low.
// R9 - With all chain inputs high the chain output is low.
// R10 - Outside test mode the chain inputs have no effect on the chain output pin.
// R11 - The mode flag changes only at host reset release or power-on reset.
module xcbt_board_test
    import xcbt_pkg::*;
(
    // Clock and power-on reset of the core supply.
    input wire logic CLOCK,
    input wire logic RST,
    // Host bus reset and the reset-sampled strap pins.
    input wire logic HOST_RESET_N,
    input wire logic LPC_FRAME_N,
    input wire logic LPC_AD0,
    // Remaining chain input pins.
    input wire logic [`XCBT_OTHER_WIDTH-1:0] CHAIN_OTHER,
    // Normal transmit data from the serial port.
    input wire logic NORMAL_SERIAL1_TX,
    // Pin outputs.
    output logic SERIAL1_TRANSMIT_PIN,
    output logic PIN_OUTPUT_DISABLE,
    output logic TEST_MODE
);

    // ****************************************************************
    // Decoding
    // ****************************************************************

    // Both strap pins low asks for the test mode.
    function automatic logic entry_request(input logic frame_n, input logic ad0);
        entry_request = !frame_n && !ad0;
    endfunction

    logic host_reset_prev;
    logic reset_release;
    xcbt_mode_t mode;
    logic [`XCBT_CHAIN_WIDTH-1:0] chain;
    logic chain_parity;

    // Supplies, grounds, the output, host reset and oscillator never reach this vector.
    assign chain = {LPC_FRAME_N, LPC_AD0, CHAIN_OTHER}; // R6 R7
    assign chain_parity = ^chain; // R5
    assign reset_release = HOST_RESET_N && !host_reset_prev;

    // ****************************************************************
    // Release detection
    // ****************************************************************

    // Starts high so that a host reset already released at power-up is not a release edge.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            host_reset_prev <= 1'b1;
        end else begin
            host_reset_prev <= HOST_RESET_N;
        end
    end

    // ****************************************************************
    // Mode flag
    // ****************************************************************

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mode <= XCBT_NORMAL; // R3
        end else if (reset_release) begin // R11
            if (entry_request(LPC_FRAME_N, LPC_AD0)) begin
                mode <= XCBT_TEST; // R1
            end else begin
                mode <= XCBT_NORMAL; // R2
            end
        end
    end

    // ****************************************************************
    // Pin outputs
    // ****************************************************************

    // The chain is registered once so the pin comes from a flip-flop; an even chain
    // length makes the all-low and all-high patterns both give low.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            SERIAL1_TRANSMIT_PIN <= `XCBT_PIN_RESET;
        end else begin
            unique case (mode)
                XCBT_TEST: begin
                    SERIAL1_TRANSMIT_PIN <= chain_parity; // R5 R8 R9
                end
                XCBT_NORMAL: begin
                    SERIAL1_TRANSMIT_PIN <= NORMAL_SERIAL1_TX; // R10
                end
                default: begin
                    SERIAL1_TRANSMIT_PIN <= `XCBT_PIN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PIN_OUTPUT_DISABLE <= `XCBT_DISABLE_RESET;
        end else begin
            PIN_OUTPUT_DISABLE <= (mode == XCBT_TEST); // R4
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            TEST_MODE <= 1'b0;
        end else begin
            TEST_MODE <= (mode == XCBT_TEST);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    enter_mode_a: assert property ( // R1
        @(posedge CLOCK) disable iff (RST)
        reset_release && !LPC_FRAME_N && !LPC_AD0 |=> mode == XCBT_TEST ##1 TEST_MODE)
        else $error("Test mode not entered at reset release.");

    leave_mode_a: assert property ( // R2
        @(posedge CLOCK) disable iff (RST)
        reset_release && (LPC_FRAME_N || LPC_AD0) |=> mode == XCBT_NORMAL ##1 !TEST_MODE)
        else $error("Test mode not left at reset release.");

    por_exit_a: assert property ( // R3
        @(posedge CLOCK)
        RST |=> mode == XCBT_NORMAL && !TEST_MODE && !PIN_OUTPUT_DISABLE)
        else $error("Power-on reset left test mode active.");

    pins_released_a: assert property ( // R4
        @(posedge CLOCK) disable iff (RST)
        ##1 PIN_OUTPUT_DISABLE == ($past(mode) == XCBT_TEST))
        else $error("Pin release does not follow the mode.");

    single_toggle_a: assert property ( // R5
        @(posedge CLOCK) disable iff (RST)
        mode == XCBT_TEST && $past(mode) == XCBT_TEST
            && $countones(chain ^ $past(chain)) == 1
            |=> SERIAL1_TRANSMIT_PIN != $past(SERIAL1_TRANSMIT_PIN))
        else $error("Chain output did not toggle on a single input change.");

    all_low_a: assert property ( // R8
        @(posedge CLOCK) disable iff (RST)
        mode == XCBT_TEST && chain == '0 |=> !SERIAL1_TRANSMIT_PIN)
        else $error("Chain output not low with all inputs low.");

    all_high_a: assert property ( // R9
        @(posedge CLOCK) disable iff (RST)
        mode == XCBT_TEST && (&chain) |=> !SERIAL1_TRANSMIT_PIN)
        else $error("Chain output not low with all inputs high.");

    normal_pass_a: assert property ( // R10
        @(posedge CLOCK) disable iff (RST)
        mode == XCBT_NORMAL |=> SERIAL1_TRANSMIT_PIN == $past(NORMAL_SERIAL1_TX))
        else $error("Chain inputs reached the pin outside test mode.");

    mode_hold_a: assert property ( // R11
        @(posedge CLOCK) disable iff (RST)
        !reset_release |=> $stable(mode))
        else $error("Mode changed without a reset release.");

    // Any change of the flag must trace back to a release one edge earlier.
    mode_change_a: assert property ( // R11
        @(posedge CLOCK) disable iff (RST)
        $changed(mode) |-> $past(reset_release))
        else $error("Mode changed with no release before it.");

    // An illegal code would leave the pin case on its default branch.
    mode_legal_a: assert property ( // R11
        @(posedge CLOCK) disable iff (RST)
        $onehot(mode))
        else $error("Mode flag holds an illegal code.");

    // The first edge after power-on reset is skipped, since the previous level is forced high.
    release_edge_a: assert property ( // R1 R2
        @(posedge CLOCK) disable iff (RST)
        !$past(RST) |-> reset_release == (HOST_RESET_N && !$past(HOST_RESET_N)))
        else $error("Release edge does not follow the host reset pin.");

    // The mode output trails the flag by the same one edge as the pin release.
    mode_output_a: assert property ( // R1 R2
        @(posedge CLOCK) disable iff (RST)
        ##1 TEST_MODE == ($past(mode) == XCBT_TEST))
        else $error("Mode output does not follow the mode flag.");

    chain_follow_a: assert property ( // R5 R6
        @(posedge CLOCK) disable iff (RST)
        mode == XCBT_TEST |=> SERIAL1_TRANSMIT_PIN == $past(chain_parity))
        else $error("Chain output does not follow the chain inputs.");

    // Host reset and the oscillator stay outside the chain, so a still chain keeps the pin still.
    chain_quiet_a: assert property ( // R6
        @(posedge CLOCK) disable iff (RST)
        mode == XCBT_TEST && $past(mode) == XCBT_TEST && $stable(chain)
            |=> $stable(SERIAL1_TRANSMIT_PIN))
        else $error("Chain output moved with the chain inputs still.");

    // The reset value of the pin is excluded, as it need not match the transmit data.
    normal_quiet_a: assert property ( // R10
        @(posedge CLOCK) disable iff (RST)
        !$past(RST) && mode == XCBT_NORMAL && $past(mode) == XCBT_NORMAL
            && $stable(NORMAL_SERIAL1_TX) |=> $stable(SERIAL1_TRANSMIT_PIN))
        else $error("Chain inputs moved the pin outside test mode.");

    por_pin_a: assert property ( // R3
        @(posedge CLOCK)
        RST |=> SERIAL1_TRANSMIT_PIN == `XCBT_PIN_RESET)
        else $error("Chain output pin not idle after power-on reset.");

endmodule
`default_nettype wire

// [sim/xcbt_tester.sv]
// Board test equipment model that drives every chain input pin.
`timescale 1ns/1ps
`default_nettype none
`include "xcbt_defines.svh"
module xcbt_tester (
    // Clock used only to time the pin changes.
    input wire logic CLOCK,
    // Pins driven by the equipment.
    output logic HOST_RESET_N,
    output logic LPC_FRAME_N,
    output logic LPC_AD0,
    output logic [`XCBT_OTHER_WIDTH-1:0] CHAIN_OTHER
);
    initial begin
        HOST_RESET_N = 1'b0;
        LPC_FRAME_N = 1'b0;
        LPC_AD0 = 1'b0;
        CHAIN_OTHER = '0;
    end
    // Straps are set while reset is low so they are settled at the release edge.
    task automatic strap(input logic f, input logic a);
        @(negedge CLOCK);
        HOST_RESET_N = 1'b0;
        LPC_FRAME_N = f;
        LPC_AD0 = a;
        @(negedge CLOCK);
        HOST_RESET_N = 1'b1;
        repeat (2) @(negedge CLOCK);
    endtask
    task automatic pin(input int i, input logic v);
        @(negedge CLOCK);
        if (i == `XCBT_FRAME_BIT) LPC_FRAME_N = v;
        else if (i == `XCBT_AD0_BIT) LPC_AD0 = v;
        else CHAIN_OTHER[i] = v;
        @(negedge CLOCK);
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench for the board test block.
`timescale 1ns/1ps
`default_nettype none
`include "xcbt_defines.svh"
module tb;
    logic clock, rst, tx, hrst_n, frame_n, ad0, pin_out, dis, mode, e;
    logic [`XCBT_OTHER_WIDTH-1:0] other;
    int error_cnt = 0;
    int n_tests = 0;
    xcbt_board_test DUT (.CLOCK(clock), .RST(rst), .HOST_RESET_N(hrst_n),
        .LPC_FRAME_N(frame_n), .LPC_AD0(ad0), .CHAIN_OTHER(other), .NORMAL_SERIAL1_TX(tx),
        .SERIAL1_TRANSMIT_PIN(pin_out), .PIN_OUTPUT_DISABLE(dis), .TEST_MODE(mode));
    xcbt_tester tester (.CLOCK(clock), .HOST_RESET_N(hrst_n), .LPC_FRAME_N(frame_n),
        .LPC_AD0(ad0), .CHAIN_OTHER(other));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic test_enter();
        tester.strap(1'b0, 1'b0);
        chk("mode", 1'b1, mode);
        chk("disable", 1'b1, dis);
        chk("chain", 1'b0, pin_out);
        $display("test enter done");
    endtask
    // Every pin is stepped, straps included, so a bit missing from the chain shows.
    task automatic test_walk();
        e = 1'b0;
        for (int i = `XCBT_CHAIN_WIDTH - 1; i >= 0; i--) begin
            tester.pin(i, 1'b1);
            e = ~e;
            chk("chain up", e, pin_out);
        end
        chk("chain high", 1'b0, pin_out);
        for (int i = 0; i < `XCBT_CHAIN_WIDTH; i++) begin
            tester.pin(i, 1'b0);
            e = ~e;
            chk("chain down", e, pin_out);
        end
        chk("chain low", 1'b0, pin_out);
        chk("mode kept", 1'b1, mode);
        $display("test walk done");
    endtask
    task automatic test_exit(input logic f, input logic a);
        tester.strap(1'b0, 1'b0);
        chk("mode kept", 1'b1, mode);
        chk("chain still", 1'b0, pin_out);
        tester.strap(f, a);
        chk("mode", 1'b0, mode);
        chk("disable", 1'b0, dis);
        @(negedge clock);
        tx = 1'b0;
        @(negedge clock);
        chk("tx", 1'b0, pin_out);
        tx = 1'b1;
        tester.pin(5, 1'b1);
        chk("tx held", 1'b1, pin_out);
        tester.pin(5, 1'b0);
        $display("test exit done");
    endtask
    task automatic test_por();
        tester.strap(1'b0, 1'b0);
        chk("mode", 1'b1, mode);
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        chk("mode", 1'b0, mode);
        chk("disable", 1'b0, dis);
        chk("pin idle", 1'b1, pin_out);
        $display("test por done");
    endtask
    initial begin
        rst = 1'b1;
        tx = 1'b1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        test_enter();
        test_walk();
        test_exit(1'b1, 1'b0);
        test_exit(1'b0, 1'b1);
        test_por();
        results();
    end
endmodule
`default_nettype wire
